// File: hdl/dcf_fifo.sv
// 1k x 18 fifo with full, empty, half and programmable flags
// How it works
// - full on write side, empty on read side
// - full clears one edge after freeing read
// - empty clears one edge after first write
// - first word readable within two edges
// - first word appears cycle after empty clears
// - reset works with clock still running
// - outputs low after reset, enable drives them
// - almost-empty deassert deferred one edge
// - almost-full deassert deferred one edge
// - almost-empty asserts when occupancy reaches offset
// - almost-full asserts at depth minus offset
// - sync select low gives synchronous prog flags
// - async mode: flags held after offset write
// - flags valid after retransmit recovery
// - async prog flags update one edge later than sync
// - both offsets reset to 127 words
//
// Register access over AHB-Lite and the register addresses are this design's own decisions.
`include "dcf_regs.svh"

module dcf_fifo (
    input  wire logic              hclk,
    input  wire logic              hresetn,
    input  wire logic              hsel,
    input  wire logic [31:0]       haddr,
    input  wire logic [1:0]        htrans,
    input  wire logic              hwrite,
    input  wire logic [2:0]        hsize,
    input  wire logic              hready,
    input  wire dcf_pkg::dcf_bus_t hwdata,
    output logic      [31:0]       hrdata,
    output logic                   hreadyout,
    output logic                   hresp,
    output logic                   irq,
    input  wire logic              write_en,
    input  wire dcf_pkg::dcf_word_t write_data_in,
    input  wire logic              read_en,
    input  wire logic              output_enable_n,
    input  wire logic              retransmit_req,
    input  wire logic              flag_sync_select,
    output dcf_pkg::dcf_word_t     read_data_out,
    output logic                   read_data_oe,
    output logic                   full_flag_n,
    output logic                   empty_flag_n,
    output logic                   almost_empty_flag_n,
    output logic                   almost_full_flag_n,
    output logic                   half_full_flag_n
);
    import dcf_pkg::*;

    // ----------------------------------------------------------------
    // timing counts
    // ----------------------------------------------------------------
    localparam int RTR_CYC    = (`DCF_RTR_NS + `DCF_CLK_NS - 1) / `DCF_CLK_NS;
    localparam int SETTLE_CYC =
        (`DCF_SETTLE_NS + `DCF_CLK_NS - 1) / `DCF_CLK_NS;

    // ----------------------------------------------------------------
    // storage and pointers
    // ----------------------------------------------------------------
    dcf_word_t mem [0:1023];
    dcf_ptr_t  wptr_r;
    dcf_ptr_t  rptr_r;
    dcf_cnt_t  count_r;
    dcf_cnt_t  count_nxt;
    logic [1:0] rtr_cnt_r;
    logic [1:0] settle_cnt_r;
    logic [9:0] empty_offs_r;
    logic [9:0] full_offs_r;
    logic       wr_ok;
    logic       rd_ok;
    logic       ae_raw;
    logic       af_raw;
    logic       ae_stage_r;
    logic       af_stage_r;

    // refusal is by the flags, which assert on the edge itself, and for reads also by retransmit recovery
    assign wr_ok = write_en && full_flag_n;
    assign rd_ok = read_en && empty_flag_n && (rtr_cnt_r == 2'h0);

    always_comb begin
        count_nxt = count_r;
        if (retransmit_req) begin
            count_nxt = {1'b0, wptr_r};
            if (wr_ok && wptr_r == 10'h3ff)
                count_nxt = `DCF_DEPTH;
            else if (wr_ok)
                count_nxt = {1'b0, wptr_r} + 11'h001;
        end else if (wr_ok && !rd_ok) begin
            count_nxt = count_r + 11'h001;
        end else if (rd_ok && !wr_ok) begin
            count_nxt = count_r - 11'h001;
        end
    end

    always_ff @(posedge hclk) begin
        if (wr_ok)
            mem[wptr_r] <= write_data_in;
    end

    // reset is asynchronous and needs no quiet clock
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wptr_r  <= 10'h000;
            rptr_r  <= 10'h000;
            count_r <= 11'h000;
        end else begin
            if (wr_ok)
                wptr_r <= wptr_r + 10'h001;
            if (retransmit_req)
                rptr_r <= 10'h000;
            else if (rd_ok)
                rptr_r <= rptr_r + 10'h001;
            count_r <= count_nxt;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn)
            rtr_cnt_r <= 2'h0;
        else if (retransmit_req)
            rtr_cnt_r <= 2'(RTR_CYC);
        else if (rtr_cnt_r != 2'h0)
            rtr_cnt_r <= rtr_cnt_r - 2'h1;
    end

    // ----------------------------------------------------------------
    // read port
    // ----------------------------------------------------------------
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            read_data_out <= 18'h00000;
            read_data_oe  <= 1'b0;
        end else begin
            if (rd_ok)
                read_data_out <= mem[rptr_r];
            read_data_oe <= !output_enable_n;
        end
    end

    // ----------------------------------------------------------------
    // flags: assert on the causing edge, empty and full release one edge late, half-full on the causing edge
    // ----------------------------------------------------------------
    // a same-edge opposite access never meets the skew minimum,
    // so empty and full releases always take the later edge
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            empty_flag_n     <= 1'b0;
            full_flag_n      <= 1'b1;
            half_full_flag_n <= 1'b1;
        end else begin
            empty_flag_n <= !(count_nxt == 11'h000 || count_r == 11'h000);
            full_flag_n  <= !(count_nxt == `DCF_DEPTH ||
                              count_r == `DCF_DEPTH);
            half_full_flag_n <= !(count_nxt > `DCF_HALF);
        end
    end

    assign ae_raw = (count_nxt <= {1'b0, empty_offs_r}) ||
                    (count_r <= {1'b0, empty_offs_r});
    assign af_raw = (count_nxt >= `DCF_DEPTH - {1'b0, full_offs_r}) ||
                    (count_r >= `DCF_DEPTH - {1'b0, full_offs_r});

    // async mode adds a stage: longer clock to flag
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ae_stage_r          <= 1'b1;
            af_stage_r          <= 1'b0;
            almost_empty_flag_n <= 1'b0;
            almost_full_flag_n  <= 1'b1;
        end else begin
            ae_stage_r <= ae_raw;
            af_stage_r <= af_raw;
            if (!flag_sync_select) begin
                almost_empty_flag_n <= !ae_raw;
                almost_full_flag_n  <= !af_raw;
            end else if (settle_cnt_r == 2'h0) begin
                almost_empty_flag_n <= !ae_stage_r;
                almost_full_flag_n  <= !af_stage_r;
            end
        end
    end

    // ----------------------------------------------------------------
    // bus slave: zero wait, always okay
    // ----------------------------------------------------------------
    logic       dph_wr_r;
    logic [7:0] dph_addr_r;
    logic       addr_ok;
    logic [`DCF_IRQ_BITS-1:0] irq_stat_r;
    logic [`DCF_IRQ_BITS-1:0] irq_mask_r;
    logic [`DCF_IRQ_BITS-1:0] irq_evt;
    logic [31:0] status_w;
    logic [31:0] rd_mux;

    assign addr_ok = hsel && htrans[1] && hready;

    assign status_w = {5'h00, count_r, 9'h000,
                       (settle_cnt_r != 2'h0), (rtr_cnt_r != 2'h0),
                       !full_flag_n, !almost_full_flag_n,
                       !half_full_flag_n, !almost_empty_flag_n,
                       !empty_flag_n};

    always_comb begin
        case (haddr[7:0])
            `DCF_EMPTY_OFFS_ADDR: rd_mux = {22'h000000, empty_offs_r};
            `DCF_FULL_OFFS_ADDR:  rd_mux = {22'h000000, full_offs_r};
            `DCF_STATUS_ADDR:     rd_mux = status_w;
            `DCF_IRQ_STAT_ADDR:   rd_mux = {28'h0000000, irq_stat_r};
            `DCF_IRQ_MASK_ADDR:   rd_mux = {28'h0000000, irq_mask_r};
            default:              rd_mux = 32'h00000000;
        endcase
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            dph_wr_r   <= 1'b0;
            dph_addr_r <= 8'h00;
            hrdata     <= 32'h00000000;
            hreadyout  <= 1'b0;
            hresp      <= 1'b0;
        end else begin
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
            if (hready)
                dph_wr_r <= addr_ok && hwrite;
            if (addr_ok) begin
                dph_addr_r <= haddr[7:0];
                if (!hwrite)
                    hrdata <= rd_mux;
            end
        end
    end

    // ----------------------------------------------------------------
    // offset registers
    // ----------------------------------------------------------------
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            empty_offs_r <= `DCF_OFFS_RST;
            full_offs_r  <= `DCF_OFFS_RST;
            settle_cnt_r <= 2'h0;
        end else begin
            if (dph_wr_r && dph_addr_r == `DCF_EMPTY_OFFS_ADDR)
                empty_offs_r <= hwdata[9:0];
            if (dph_wr_r && dph_addr_r == `DCF_FULL_OFFS_ADDR)
                full_offs_r <= hwdata[9:0];
            if (dph_wr_r && (dph_addr_r == `DCF_EMPTY_OFFS_ADDR ||
                             dph_addr_r == `DCF_FULL_OFFS_ADDR))
                settle_cnt_r <= 2'(SETTLE_CYC + 1);
            else if (settle_cnt_r != 2'h0)
                settle_cnt_r <= settle_cnt_r - 2'h1;
        end
    end

    // ----------------------------------------------------------------
    // interrupts: sticky, write one to clear, set wins
    // ----------------------------------------------------------------
    assign irq_evt[`DCF_IRQ_OVERFLOW]  = write_en && !full_flag_n;
    assign irq_evt[`DCF_IRQ_UNDERFLOW] = read_en && !empty_flag_n;
    assign irq_evt[`DCF_IRQ_AEMPTY]    = almost_empty_flag_n && ae_raw;
    assign irq_evt[`DCF_IRQ_AFULL]     = almost_full_flag_n && af_raw;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            irq_stat_r <= '0;
            irq_mask_r <= '0;
            irq        <= 1'b0;
        end else begin
            if (dph_wr_r && dph_addr_r == `DCF_IRQ_STAT_ADDR)
                irq_stat_r <= (irq_stat_r & ~hwdata[`DCF_IRQ_BITS-1:0])
                              | irq_evt;
            else
                irq_stat_r <= irq_stat_r | irq_evt;
            if (dph_wr_r && dph_addr_r == `DCF_IRQ_MASK_ADDR)
                irq_mask_r <= hwdata[`DCF_IRQ_BITS-1:0];
            irq <= |(irq_stat_r & irq_mask_r);
        end
    end

endmodule

// File: hdl/dcf_regs.svh
// register offsets, reset values and nanosecond timings of the flag fifo
`ifndef DCF_REGS_SVH
`define DCF_REGS_SVH

// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define DCF_EMPTY_OFFS_ADDR 8'h00
`define DCF_FULL_OFFS_ADDR  8'h04
`define DCF_STATUS_ADDR     8'h08
`define DCF_IRQ_STAT_ADDR   8'h0c
`define DCF_IRQ_MASK_ADDR   8'h10

// ----------------------------------------------------------------
// sizes and reset values
// ----------------------------------------------------------------
`define DCF_DEPTH           11'h400
`define DCF_HALF            11'h200
`define DCF_OFFS_RST        10'h07f
`define DCF_IRQ_BITS        4

// ----------------------------------------------------------------
// status field positions
// ----------------------------------------------------------------
`define DCF_ST_EMPTY        0
`define DCF_ST_AEMPTY       1
`define DCF_ST_HALF         2
`define DCF_ST_AFULL        3
`define DCF_ST_FULL         4
`define DCF_ST_RTR          5
`define DCF_ST_SETTLE       6
`define DCF_ST_COUNT_LSB    16

// ----------------------------------------------------------------
// irq status bits
// ----------------------------------------------------------------
`define DCF_IRQ_OVERFLOW    0
`define DCF_IRQ_UNDERFLOW   1
`define DCF_IRQ_AEMPTY      2
`define DCF_IRQ_AFULL       3

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define DCF_CLK_NS          10
`define DCF_RTR_NS          12
`define DCF_SETTLE_NS       5

`endif

// File: hdl/dcf_pkg.sv
// types shared by the flag fifo
package dcf_pkg;
    typedef logic [17:0] dcf_word_t;
    typedef logic [9:0]  dcf_ptr_t;
    typedef logic [10:0] dcf_cnt_t;
    typedef logic [31:0] dcf_bus_t;
endpackage

// File: sim/dcf_fifo_asserts.sv
// port checks for the flag fifo
module dcf_fifo_asserts (
    input wire logic               hclk,
    input wire logic               hresetn,
    input wire logic               hreadyout,
    input wire logic               hresp,
    input wire logic               write_en,
    input wire logic               read_en,
    input wire logic               retransmit_req,
    input wire logic               flag_sync_select,
    input wire logic               output_enable_n,
    input wire dcf_pkg::dcf_word_t read_data_out,
    input wire logic               read_data_oe,
    input wire logic               full_flag_n,
    input wire logic               empty_flag_n,
    input wire logic               almost_full_flag_n
);
    import dcf_pkg::*;
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    empty_rel_a: assert property (
        !empty_flag_n && write_en && !retransmit_req |-> ##2 empty_flag_n)
        else $error("empty flag late after first write");
    empty_cause_a: assert property (
        $fell(empty_flag_n) |-> $past(read_en))
        else $error("empty flag set without a read");
    full_cause_a: assert property (
        $rose(full_flag_n) |-> $past(read_en, 2))
        else $error("full flag cleared without a read");
    full_keep_a: assert property (
        !full_flag_n && !read_en && !$past(read_en) |=> !full_flag_n)
        else $error("full flag cleared with no read");
    oe_follow_a: assert property (
        $past(hresetn) |-> read_data_oe == !$past(output_enable_n))
        else $error("output enable does not follow");
    data_hold_a: assert property (
        !read_en |=> $stable(read_data_out))
        else $error("read data moved without a read");
    rtr_hold_a: assert property (
        retransmit_req |=> ##1 $stable(read_data_out))
        else $error("read taken during recovery");
    full_af_a: assert property (
        !full_flag_n && !flag_sync_select |-> !almost_full_flag_n)
        else $error("full without almost full");
    bus_ok_a: assert property (
        $past(hresetn) |-> hreadyout && !hresp)
        else $error("bus not ready or error after reset");
    cover property ($rose(empty_flag_n));
    cover property ($fell(full_flag_n));
    cover property (retransmit_req);
endmodule

bind dcf_fifo dcf_fifo_asserts u_dcf_fifo_asserts (.hclk(hclk),
    .hresetn(hresetn), .hreadyout(hreadyout), .hresp(hresp),
    .write_en(write_en), .read_en(read_en),
    .retransmit_req(retransmit_req), .flag_sync_select(flag_sync_select),
    .output_enable_n(output_enable_n), .read_data_out(read_data_out),
    .read_data_oe(read_data_oe), .full_flag_n(full_flag_n),
    .empty_flag_n(empty_flag_n), .almost_full_flag_n(almost_full_flag_n));

// File: sim/dcf_peer.sv
// writer and reader logic on the fifo side
module dcf_peer (
    input  wire logic          hclk,
    output logic               write_en,
    output dcf_pkg::dcf_word_t write_data_in,
    output logic               read_en
);
    import dcf_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        write_en = 1'b0;
        read_en = 1'b0;
        write_data_in = '0;
    end
    task automatic put(input int n, input dcf_word_t d0);
        for (int i = 0; i < n; i++) begin
            @(posedge hclk);
            write_en <= 1'b1;
            write_data_in <= d0 + dcf_word_t'(i);
        end
        @(posedge hclk);
        write_en <= 1'b0;
        // idle bus shows no stale word
        write_data_in <= ~(d0 + dcf_word_t'(n - 1));
    endtask
    task automatic get(input int n);
        repeat (n) @(posedge hclk) read_en <= 1'b1;
        @(posedge hclk);
        read_en <= 1'b0;
    endtask
endmodule

// File: sim/dcf_fifo_tb_top.sv
// flag fifo bench: registers, irq, fill, drain, retransmit
`include "dcf_regs.svh"
module dcf_fifo_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import dcf_pkg::*;
    logic        hclk, hresetn, hsel, hwrite, retransmit_req, irq;
    logic        output_enable_n, flag_sync_select, hreadyout, hresp;
    logic [31:0] haddr, hrdata;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    dcf_bus_t    hwdata, rd;
    dcf_word_t   write_data_in, read_data_out;
    logic        write_en, read_en, read_data_oe, full_flag_n;
    logic        empty_flag_n, almost_empty_flag_n, almost_full_flag_n;
    logic        half_full_flag_n;
    int          n_fail, compares;
    dcf_fifo u_dcf_fifo (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
        .hready(hreadyout), .hwdata(hwdata), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .irq(irq),
        .write_en(write_en), .write_data_in(write_data_in),
        .read_en(read_en), .output_enable_n(output_enable_n),
        .retransmit_req(retransmit_req),
        .flag_sync_select(flag_sync_select),
        .read_data_out(read_data_out), .read_data_oe(read_data_oe),
        .full_flag_n(full_flag_n), .empty_flag_n(empty_flag_n),
        .almost_empty_flag_n(almost_empty_flag_n),
        .almost_full_flag_n(almost_full_flag_n),
        .half_full_flag_n(half_full_flag_n));
    dcf_peer u_dcf_peer (.hclk(hclk), .write_en(write_en),
        .write_data_in(write_data_in), .read_en(read_en));
    initial begin
        hclk = 1'b0;
        forever #5 hclk = ~hclk;
    end
    // ----------------------------------------
    // shared tasks
    // ----------------------------------------
    task automatic bus(input logic w, input logic [7:0] a,
                       input dcf_bus_t wd, output dcf_bus_t q);
        @(posedge hclk);
        hsel <= 1'b1;
        htrans <= 2'b10;
        hwrite <= w;
        haddr <= {24'h0, a};
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= wd;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        q = hrdata;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            n_fail++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    task automatic report_and_stop();
        $display("compares %0d mismatches %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    initial begin
        repeat (5000) @(posedge hclk);
        n_fail++;
        report_and_stop();
    end
    // ----------------------------------------
    // tests
    // ----------------------------------------
    initial begin
        {hresetn, hsel, hwrite, retransmit_req} = '0;
        {output_enable_n, flag_sync_select, haddr, htrans} = '0;
        hsize = 3'b010;
        hwdata = '0;
        n_fail = 0;
        compares = 0;
        repeat (16) @(posedge hclk);
        hresetn <= 1'b1;
        repeat (2) @(posedge hclk);
        #1;
        chk(read_data_out, 32'h0);
        chk(read_data_oe, 32'h1);
        chk({full_flag_n, empty_flag_n, almost_empty_flag_n,
             almost_full_flag_n, half_full_flag_n}, 32'h13);
        @(posedge hclk) output_enable_n <= 1'b1;
        repeat (2) @(posedge hclk);
        #1;
        chk(read_data_oe, 32'h0);
        bus(0, `DCF_EMPTY_OFFS_ADDR, 0, rd);
        chk(rd, 32'h7f);
        bus(0, `DCF_FULL_OFFS_ADDR, 0, rd);
        chk(rd, 32'h7f);
        bus(1, 8'h14, 32'hffff, rd);
        bus(0, 8'h14, 0, rd);
        chk(rd, 32'h0);
        $display("test reset and registers done");
        u_dcf_peer.put(1, 18'h2a5c3);
        #1;
        chk(empty_flag_n, 32'h0);
        @(posedge hclk);
        #1;
        chk(empty_flag_n, 32'h1);
        u_dcf_peer.get(1);
        #1;
        chk(read_data_out, 32'h2a5c3);
        chk(empty_flag_n, 32'h0);
        u_dcf_peer.get(1);
        chk(irq, 32'h0);
        bus(0, `DCF_IRQ_STAT_ADDR, 0, rd);
        chk(rd, 32'h2);
        bus(1, `DCF_IRQ_MASK_ADDR, 32'h2, rd);
        bus(0, `DCF_STATUS_ADDR, 0, rd);
        chk(irq, 32'h1);
        bus(1, `DCF_IRQ_STAT_ADDR, 32'h2, rd);
        bus(0, `DCF_STATUS_ADDR, 0, rd);
        chk(irq, 32'h0);
        $display("test first word and irq done");
        u_dcf_peer.put(896, 18'h0);
        #1;
        chk(almost_full_flag_n, 32'h1);
        u_dcf_peer.put(1, 18'h380);
        #1;
        chk(almost_full_flag_n, 32'h0);
        u_dcf_peer.put(128, 18'h381);
        #1;
        chk({full_flag_n, half_full_flag_n}, 32'h0);
        bus(0, `DCF_STATUS_ADDR, 0, rd);
        chk(rd[26:16], 32'h400);
        u_dcf_peer.get(896);
        #1;
        chk(almost_empty_flag_n, 32'h1);
        chk(read_data_out, 32'h37f);
        u_dcf_peer.get(2);
        #1;
        chk(almost_empty_flag_n, 32'h0);
        chk(read_data_out, 32'h381);
        $display("test fill and drain done");
        @(posedge hclk) hresetn <= 1'b0;
        repeat (3) @(posedge hclk);
        hresetn <= 1'b1;
        repeat (2) @(posedge hclk);
        u_dcf_peer.put(3, 18'h100);
        u_dcf_peer.get(2);
        @(posedge hclk) retransmit_req <= 1'b1;
        @(posedge hclk) retransmit_req <= 1'b0;
        repeat (2) @(posedge hclk);
        u_dcf_peer.get(1);
        #1;
        chk(read_data_out, 32'h100);
        chk(empty_flag_n, 32'h1);
        // async mode: new offset only seen after the settle time
        @(posedge hclk) flag_sync_select <= 1'b1;
        bus(1, `DCF_EMPTY_OFFS_ADDR, 32'h0, rd);
        #1;
        chk(almost_empty_flag_n, 32'h0);
        repeat (5) @(posedge hclk);
        #1;
        chk(almost_empty_flag_n, 32'h1);
        $display("test retransmit done");
        report_and_stop();
    end
endmodule
